// *** logic/etm_pkg.sv ***
// Shared constants for the enhanced timer: register map, field positions,
// reset values, mode and clock-source codes.
// Assumes a 32-bit APB slave with one byte-wide register per aligned word.
package etm_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL0 = 8'h00;
	localparam logic [7:0] OFS_CONTROL1 = 8'h04;
	localparam logic [7:0] OFS_CONTROL2 = 8'h08;
	localparam logic [7:0] OFS_COUNT_LOW = 8'h0C;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h10;
	localparam logic [7:0] OFS_COMPARE_A_LOW = 8'h14;
	localparam logic [7:0] OFS_COMPARE_A_HIGH = 8'h18;
	localparam logic [7:0] OFS_COMPARE_B_LOW = 8'h1C;
	localparam logic [7:0] OFS_COMPARE_B_HIGH = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_PAUSE = 7;
	localparam int POS_CLOCK_SOURCE = 4;
	localparam int POS_RUN = 3;
	localparam int POS_PERIOD = 0;
	localparam int POS_MODE = 6;
	localparam int POS_FUNC = 4;
	localparam int POS_OUT_CTRL = 3;
	localparam int POS_POLARITY = 2;
	localparam int POS_DIRECTION = 1;
	localparam int POS_CLEAR_SEL = 0;
	localparam int POS_ALIGN = 0;

	// ----------------------------------------------------------------
	// Reset values and widths
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [9:0] RST_COMPARE = 10'h000;
	localparam logic [9:0] COUNT_MAX = 10'h3FF;
	localparam logic [31:0] ERR_READ = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;

	localparam logic [1:0] FUNC_0 = 2'h0;
	localparam logic [1:0] FUNC_1 = 2'h1;
	localparam logic [1:0] FUNC_2 = 2'h2;
	localparam logic [1:0] FUNC_3 = 2'h3;

	localparam logic [2:0] SRC_SYS_DIV4 = 3'h0;
	localparam logic [2:0] SRC_SYS = 3'h1;
	localparam logic [2:0] SRC_HS_DIV16 = 3'h2;
	localparam logic [2:0] SRC_HS_DIV64 = 3'h3;
	localparam logic [2:0] SRC_TIME_BASE = 3'h4;
	localparam logic [2:0] SRC_UNDEFINED = 3'h5;
	localparam logic [2:0] SRC_PIN_RISE = 3'h6;
	localparam logic [2:0] SRC_PIN_FALL = 3'h7;

endpackage

// *** logic/etm_timer.sv ***
// Enhanced 10-bit timer with period comparator and two compare/capture
// channels, reached over APB.
// Assumes all pin inputs are synchronous to REF_CLK and the high-speed clock
// equals REF_CLK; the time-base clock arrives as a one-cycle tick.
//
// Notes on behaviour
// - Ten-bit counter, internal or pin clock.
// - Period compares top three bits; A,B full.
// - Software only clears counter via run rise.
// - Overflow or selected match clears, flags event.
// - Pause holds count; release resumes counting.
// - Clock source field picks counting tick.
// - Source code 101 stops the counter.
// - Run off stops, keeps value; on clears.
// - Compare mode: run rise restores initial level.
// - Period match every n times 128 ticks.
// - Clear-select zero: period match clears counter; code: only overflow clears in pulse mode.
// - Period zero: counter clears by overflow.
// - Mode field selects compare/capture/PWM/timer.
// - Timer mode leaves output pin undriven.
// - Compare match: keep, low, high, toggle.
// - PWM field: inactive, active, PWM, pulse.
// - Count read-only; compare pairs read/write.
// - External clock pin, up to four outputs.
// - Direction flag reads zero counting up.
// - Clear-select one: comparator A clears; code: period match clears with A in capture mode, only overflow in pulse mode.
// - Output control sets initial/active level.
// - Polarity bit inverts output pin.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module etm_timer
(
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_CLOCK_PIN,
	input wire logic TIME_BASE_TICK,
	input wire logic CHAN_A_IN,
	input wire logic CHAN_B_IN,
	output logic CHAN_A_OUT,
	output logic CHAN_A_OE,
	output logic [2:0] CHAN_B_OUT,
	output logic [2:0] CHAN_B_OE,
	output logic TIMER_EVENT
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] control0, control1, control2;
	logic [9:0] cmp [2];
	logic [9:0] cnt;
	logic run_q;
	logic [5:0] prescale;
	logic ext_q;
	logic [1:0] in_q;
	logic [1:0] state;

	logic pause, run, clear_sel;
	logic [2:0] src, period;
	logic [1:0] mode [2];
	logic [1:0] func [2];
	logic [1:0] out_ctrl, polarity, in_pin;

	assign pause = control0[etm_pkg::POS_PAUSE];
	assign src = control0[etm_pkg::POS_CLOCK_SOURCE +: 3];
	assign run = control0[etm_pkg::POS_RUN];
	assign period = control0[etm_pkg::POS_PERIOD +: 3];
	assign clear_sel = control1[etm_pkg::POS_CLEAR_SEL];
	assign mode[0] = control1[etm_pkg::POS_MODE +: 2];
	assign mode[1] = control2[etm_pkg::POS_MODE +: 2];
	assign func[0] = control1[etm_pkg::POS_FUNC +: 2];
	assign func[1] = control2[etm_pkg::POS_FUNC +: 2];
	assign out_ctrl = {control2[etm_pkg::POS_OUT_CTRL], control1[etm_pkg::POS_OUT_CTRL]};
	assign polarity = {control2[etm_pkg::POS_POLARITY], control1[etm_pkg::POS_POLARITY]};
	assign in_pin = {CHAN_B_IN, CHAN_A_IN};

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup, wr, mapped;
	logic [7:0] rd_byte;

	assign setup = PSEL && !PENABLE;
	assign wr = PSEL && PENABLE && PREADY && PWRITE;

	always_comb
	begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		unique case (PADDR)
			etm_pkg::OFS_CONTROL0: rd_byte = control0;
			etm_pkg::OFS_CONTROL1: rd_byte = control1;
			etm_pkg::OFS_CONTROL2: rd_byte = control2;
			etm_pkg::OFS_COUNT_LOW: rd_byte = cnt[7:0];
			etm_pkg::OFS_COUNT_HIGH: rd_byte = {6'h00, cnt[9:8]};
			etm_pkg::OFS_COMPARE_A_LOW: rd_byte = cmp[0][7:0];
			etm_pkg::OFS_COMPARE_A_HIGH: rd_byte = {6'h00, cmp[0][9:8]};
			etm_pkg::OFS_COMPARE_B_LOW: rd_byte = cmp[1][7:0];
			etm_pkg::OFS_COMPARE_B_HIGH: rd_byte = {6'h00, cmp[1][9:8]};
			default: mapped = 1'b0;
		endcase
	end

	// No wait state: the answer is registered in the setup cycle
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			PREADY <= 1'b0;
			PRDATA <= etm_pkg::ERR_READ;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= setup;
			PSLVERR <= setup && !mapped;
			if (setup)
				PRDATA <= {24'h00_0000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Clock source selection
	// ----------------------------------------------------------------
	logic tick, pin_rise, pin_fall;

	assign pin_rise = EXT_CLOCK_PIN && !ext_q;
	assign pin_fall = !EXT_CLOCK_PIN && ext_q;

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			prescale <= 6'h00;
			ext_q <= 1'b0;
			in_q <= 2'h0;
		end
		else
		begin
			prescale <= prescale + 6'h01;
			ext_q <= EXT_CLOCK_PIN;
			in_q <= in_pin;
		end
	end

	always_comb
	begin
		unique case (src)
			etm_pkg::SRC_SYS_DIV4: tick = &prescale[1:0];
			etm_pkg::SRC_SYS: tick = 1'b1;
			etm_pkg::SRC_HS_DIV16: tick = &prescale[3:0];
			etm_pkg::SRC_HS_DIV64: tick = &prescale;
			etm_pkg::SRC_TIME_BASE: tick = TIME_BASE_TICK;
			etm_pkg::SRC_UNDEFINED: tick = 1'b0;
			etm_pkg::SRC_PIN_RISE: tick = pin_rise;
			etm_pkg::SRC_PIN_FALL: tick = pin_fall;
		endcase
	end

	// ----------------------------------------------------------------
	// Counter and comparators
	// ----------------------------------------------------------------
	logic run_rise, cnt_en, overflow, match_p, clear;
	logic [10:0] inc;
	logic [1:0] match;

	assign run_rise = run && !run_q;
	assign cnt_en = run && !pause && tick && !run_rise;
	assign inc = {1'b0, cnt} + 11'h001;
	assign overflow = inc[10];
	// Match on the incremented value so a code n gives exactly n*128 ticks
	assign match_p = (period != 3'h0) && (inc[9:7] == period) && (inc[6:0] == 7'h00);
	assign match[0] = inc[9:0] == cmp[0];
	assign match[1] = inc[9:0] == cmp[1];

	always_comb
	begin
		if (mode[0] == etm_pkg::MODE_PWM && func[0] == etm_pkg::FUNC_3)
			clear = overflow;
		else if (clear_sel && mode[0] != etm_pkg::MODE_CAPTURE)
			clear = match[0] || overflow;
		else
			clear = match_p || overflow;
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cnt <= 10'h000;
			run_q <= 1'b0;
		end
		else
		begin
			run_q <= run;
			if (run_rise)
				cnt <= 10'h000;
			else if (cnt_en)
				cnt <= clear ? 10'h000 : inc[9:0];
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic pulse_mode;
	logic pulse_end;

	assign pulse_mode = mode[0] == etm_pkg::MODE_PWM && func[0] == etm_pkg::FUNC_3;
	assign pulse_end = pulse_mode && cnt_en && match[0];

	// Mode bits are taken as written; software stops the timer first
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			control0 <= etm_pkg::RST_CONTROL;
			control1 <= etm_pkg::RST_CONTROL;
			control2 <= etm_pkg::RST_CONTROL;
		end
		else
		begin
			if (wr && PADDR == etm_pkg::OFS_CONTROL0)
				control0 <= PWDATA[7:0];
			else if (pulse_mode && !run && pin_rise)
				control0[etm_pkg::POS_RUN] <= 1'b1;
			else if (pulse_end)
				control0[etm_pkg::POS_RUN] <= 1'b0;
			if (wr && PADDR == etm_pkg::OFS_CONTROL1)
				control1 <= {PWDATA[7:2], 1'b0, PWDATA[0]};
			if (wr && PADDR == etm_pkg::OFS_CONTROL2)
				control2 <= {PWDATA[7:2], 1'b0, PWDATA[0]};
		end
	end

	// ----------------------------------------------------------------
	// Per-channel compare registers, capture and output state
	// ----------------------------------------------------------------
	logic [1:0] capture;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			logic rise, fall, edge_hit;
			logic [7:0] lo_ofs, hi_ofs;

			assign lo_ofs = ch == 0 ? etm_pkg::OFS_COMPARE_A_LOW : etm_pkg::OFS_COMPARE_B_LOW;
			assign hi_ofs = ch == 0 ? etm_pkg::OFS_COMPARE_A_HIGH : etm_pkg::OFS_COMPARE_B_HIGH;
			assign rise = in_pin[ch] && !in_q[ch];
			assign fall = !in_pin[ch] && in_q[ch];

			always_comb
			begin
				unique case (func[ch])
					etm_pkg::FUNC_0: edge_hit = rise;
					etm_pkg::FUNC_1: edge_hit = fall;
					etm_pkg::FUNC_2: edge_hit = rise || fall;
					etm_pkg::FUNC_3: edge_hit = 1'b0;
				endcase
			end

			assign capture[ch] = mode[ch] == etm_pkg::MODE_CAPTURE && run && edge_hit;

			always_ff @(posedge REF_CLK or negedge NRST)
			begin
				if (!NRST)
					cmp[ch] <= etm_pkg::RST_COMPARE;
				else if (capture[ch])
					cmp[ch] <= cnt;
				else if (wr && PADDR == lo_ofs)
					cmp[ch][7:0] <= PWDATA[7:0];
				else if (wr && PADDR == hi_ofs)
					cmp[ch][9:8] <= PWDATA[1:0];
			end

			// State holds the pin level before polarity
			always_ff @(posedge REF_CLK or negedge NRST)
			begin
				if (!NRST)
					state[ch] <= 1'b0;
				else if (mode[ch] == etm_pkg::MODE_COMPARE)
				begin
					if (run_rise)
						state[ch] <= out_ctrl[ch];
					else if (cnt_en && match[ch])
					begin
						unique case (func[ch])
							etm_pkg::FUNC_0: state[ch] <= state[ch];
							etm_pkg::FUNC_1: state[ch] <= 1'b0;
							etm_pkg::FUNC_2: state[ch] <= 1'b1;
							etm_pkg::FUNC_3: state[ch] <= !state[ch];
						endcase
					end
				end
				else if (mode[ch] == etm_pkg::MODE_PWM)
				begin
					unique case (func[ch])
						etm_pkg::FUNC_0: state[ch] <= !out_ctrl[ch];
						etm_pkg::FUNC_1: state[ch] <= out_ctrl[ch];
						etm_pkg::FUNC_2: state[ch] <= (cnt < cmp[ch]) ? out_ctrl[ch] : !out_ctrl[ch];
						etm_pkg::FUNC_3: state[ch] <= run ? out_ctrl[ch] : !out_ctrl[ch];
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pins and event
	// ----------------------------------------------------------------
	logic [1:0] drive;

	assign drive[0] = mode[0] == etm_pkg::MODE_COMPARE || mode[0] == etm_pkg::MODE_PWM;
	assign drive[1] = mode[1] == etm_pkg::MODE_COMPARE || mode[1] == etm_pkg::MODE_PWM;

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			CHAN_A_OUT <= 1'b0;
			CHAN_A_OE <= 1'b0;
			CHAN_B_OUT <= 3'h0;
			CHAN_B_OE <= 3'h0;
			TIMER_EVENT <= 1'b0;
		end
		else
		begin
			CHAN_A_OUT <= state[0] ^ polarity[0];
			CHAN_A_OE <= drive[0];
			CHAN_B_OUT <= {3{state[1] ^ polarity[1]}};
			CHAN_B_OE <= {3{drive[1]}};
			TIMER_EVENT <= (cnt_en && (match_p || overflow || |match)) || |capture;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	property p_run_clear;
		run_rise |=> cnt == 10'h000;
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("Counter not cleared on run rise");
	property p_pause_hold;
		pause && !run_rise |=> $stable(cnt);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("Counter moved while paused");
	property p_undef_stop;
		src == etm_pkg::SRC_UNDEFINED && !run_rise |=> $stable(cnt);
	endproperty
	a_undef_stop: assert property (p_undef_stop) else $error("Counter moved with undefined source");
	property p_off_hold;
		!run ##1 !run |-> $stable(cnt);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("Counter moved while off");
	property p_sys_count;
		run && !pause && !run_rise && src == etm_pkg::SRC_SYS && !clear |=> cnt == $past(cnt) + 10'h001;
	endproperty
	a_sys_count: assert property (p_sys_count) else $error("Counter did not step on system clock");
	property p_period_clear;
		cnt_en && !clear_sel && mode[0] == etm_pkg::MODE_COMPARE && match_p |=> cnt == 10'h000;
	endproperty
	a_period_clear: assert property (p_period_clear) else $error("Period match did not clear");
	property p_overflow;
		cnt_en && period == 3'h0 && cnt == etm_pkg::COUNT_MAX |=> cnt == 10'h000;
	endproperty
	a_overflow: assert property (p_overflow) else $error("Counter did not wrap at maximum");
	property p_timer_undriven;
		mode[0] == etm_pkg::MODE_TIMER |=> !CHAN_A_OE;
	endproperty
	a_timer_undriven: assert property (p_timer_undriven) else $error("Output driven in timer mode");
	property p_initial_level;
		mode[0] == etm_pkg::MODE_COMPARE && run_rise |=> ##1 CHAN_A_OUT == (out_ctrl[0] ^ polarity[0]);
	endproperty
	a_initial_level: assert property (p_initial_level) else $error("Initial level not restored");
	property p_toggle;
		mode[0] == etm_pkg::MODE_COMPARE && func[0] == etm_pkg::FUNC_3 && cnt_en && match[0]
			|=> state[0] != $past(state[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("Compare match did not toggle");
endmodule

// *** verification/etm_pins_model.sv ***
// Far-side pin model: external clock pin and time-base tick.
// Assumes REF_CLK from the bench; pins change just after rising edges.
`timescale 1ns/1ps

module etm_pins_model
#(
	parameter int HALF = 2,
	parameter int TB_DIV = 3
)
(
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic EN,
	output logic EXT_CLOCK_PIN,
	output logic TIME_BASE_TICK
);
	int pin_cnt;
	int tb_cnt;

	// Pin stays low while disabled, so no stray edge can count or trigger
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pin_cnt <= 0;
			EXT_CLOCK_PIN <= 1'b0;
		end
		else if (!EN || pin_cnt == HALF - 1)
		begin
			pin_cnt <= 0;
			EXT_CLOCK_PIN <= EN & ~EXT_CLOCK_PIN;
		end
		else
			pin_cnt <= pin_cnt + 1;
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			tb_cnt <= 0;
		else
			tb_cnt <= (tb_cnt == TB_DIV - 1) ? 0 : tb_cnt + 1;
	end

	assign TIME_BASE_TICK = (tb_cnt == TB_DIV - 1);
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the enhanced timer: APB master and pin model.
// Assumes etm_pkg, etm_timer and etm_pins_model are compiled first.
`timescale 1ns/1ps

module testbench;
	localparam int HALF = 2;
	localparam int TB_DIV = 3;
	logic clk;
	logic nrst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin_en;
	logic ext_pin;
	logic tb_tick;
	logic a_out;
	logic a_oe;
	logic [2:0] b_out;
	logic [2:0] b_oe;
	logic ev;
	logic [31:0] q;
	logic e;
	logic [9:0] v;
	logic [7:0] d;
	logic oc;
	logic pol;
	logic cap_in;
	int n;
	int n_mismatch;
	int check_count;
	int div[8];

	etm_timer uut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_CLOCK_PIN(ext_pin), .TIME_BASE_TICK(tb_tick), .CHAN_A_IN(cap_in), .CHAN_B_IN(cap_in),
		.CHAN_A_OUT(a_out), .CHAN_A_OE(a_oe), .CHAN_B_OUT(b_out), .CHAN_B_OE(b_oe), .TIMER_EVENT(ev));

	etm_pins_model #(.HALF(HALF), .TB_DIV(TB_DIV)) pins (.REF_CLK(clk), .NRST(nrst), .EN(pin_en),
		.EXT_CLOCK_PIN(ext_pin), .TIME_BASE_TICK(tb_tick));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// --------------------------------------------------------------
	// APB master
	// --------------------------------------------------------------
	task automatic apb(input logic wr_i, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr_i;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		apb(1'b1, a, {24'h00_0000, wd});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk("read data", {24'h00_0000, exp}, q);
	endtask

	task automatic ctl0(input logic [7:0] wd);
		wr(etm_pkg::OFS_CONTROL0, wd);
	endtask

	// --------------------------------------------------------------
	// Pin and event checks
	// --------------------------------------------------------------
	task automatic pin(input logic exp);
		chk("chan a out", 32'(exp), 32'(a_out));
		chk("chan b out", 32'({3{exp}}), 32'(b_out));
		chk("output enables", 32'h0000_000F, 32'({a_oe, b_oe}));
	endtask

	// Spacing between two events, so the first partial period is ignored
	task automatic gap(input int exp);
		int k;
		k = 0;
		while (ev !== 1'b1 && k < 20000)
		begin
			@(posedge clk);
			k++;
		end
		@(posedge clk);
		k = 1;
		while (ev !== 1'b1 && k < 20000)
		begin
			@(posedge clk);
			k++;
		end
		chk("event gap", exp, k);
		if (k >= 20000)
			end_of_test();
	endtask

	function automatic logic cmp_level(input logic [1:0] f, input logic oc_i);
		case (f)
			2'h1: return 1'b0;
			2'h2: return 1'b1;
			2'h3: return ~oc_i;
			default: return oc_i;
		endcase
	endfunction

	task automatic set_mode(input logic [1:0] m, input logic [1:0] f);
		oc = 1'($urandom);
		pol = 1'($urandom);
		ctl0(8'h00);
		wr(etm_pkg::OFS_CONTROL1, {m, f, oc, pol, 2'b00});
		wr(etm_pkg::OFS_CONTROL2, {m, f, oc, pol, 2'b00});
		ctl0(8'h19);
		repeat (5) @(posedge clk);
	endtask

	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pin_en = 1'b0;
		cap_in = 1'b0;
		n_mismatch = 0;
		check_count = 0;
		div = '{4, 1, 16, 64, TB_DIV, 0, 2 * HALF, 2 * HALF};
		void'($urandom(47));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++)
			rd(8'(4 * i), 8'h00);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk("slave error", 32'h0000_0001, 32'(e));
		wr(etm_pkg::OFS_CONTROL1, 8'hFF);
		rd(etm_pkg::OFS_CONTROL1, 8'hFD);
		wr(etm_pkg::OFS_CONTROL2, 8'hFF);
		rd(etm_pkg::OFS_CONTROL2, 8'hFD);
		for (int i = 0; i < 2; i++)
		begin
			v = 10'($urandom);
			wr(etm_pkg::OFS_COMPARE_A_LOW + 8'(8 * i), v[7:0]);
			wr(etm_pkg::OFS_COMPARE_A_HIGH + 8'(8 * i), {6'h00, v[9:8]});
			rd(etm_pkg::OFS_COMPARE_A_LOW + 8'(8 * i), v[7:0]);
			rd(etm_pkg::OFS_COMPARE_A_HIGH + 8'(8 * i), {6'h00, v[9:8]});
		end
		for (int i = 0; i < 4; i++)
			wr(etm_pkg::OFS_COMPARE_A_LOW + 8'(4 * i), 8'h00);
		$display("test registers done");
		wr(etm_pkg::OFS_CONTROL1, 8'hC0);
		wr(etm_pkg::OFS_CONTROL2, 8'hC0);
		for (int p = 0; p < 8; p++)
		begin
			ctl0(8'h00);
			ctl0(8'(8'h18 | p));
			gap(p == 0 ? 1024 : 128 * p);
		end
		chk("output enables", 32'h0000_0000, 32'({a_oe, b_oe}));
		pin_en <= 1'b1;
		for (int s = 0; s < 8; s++)
		begin
			ctl0(8'h00);
			ctl0(8'(s * 16 + 9));
			if (s != 5)
				gap(128 * div[s]);
			else
			begin
				n = 0;
				repeat (1500)
				begin
					@(posedge clk);
					n += int'(ev === 1'b1);
				end
				chk("event count", 0, n);
				rd(etm_pkg::OFS_COUNT_LOW, 8'h00);
			end
		end
		pin_en <= 1'b0;
		$display("test periods and sources done");
		ctl0(8'h00);
		ctl0(8'h18);
		ctl0(8'h98);
		rd(etm_pkg::OFS_COUNT_LOW, 8'h02);
		wr(etm_pkg::OFS_COUNT_LOW, 8'h55);
		rd(etm_pkg::OFS_COUNT_LOW, 8'h02);
		rd(etm_pkg::OFS_COUNT_HIGH, 8'h00);
		ctl0(8'h18);
		ctl0(8'h10);
		repeat (50) @(posedge clk);
		rd(etm_pkg::OFS_COUNT_LOW, 8'h05);
		ctl0(8'h18);
		ctl0(8'h98);
		rd(etm_pkg::OFS_COUNT_LOW, 8'h02);
		d = 8'(20 + $urandom % 180);
		ctl0(8'h00);
		wr(etm_pkg::OFS_CONTROL1, 8'hC1);
		wr(etm_pkg::OFS_COMPARE_A_LOW, d);
		ctl0(8'h18);
		gap(int'(d));
		$display("test pause run and clear done");
		wr(etm_pkg::OFS_COMPARE_A_LOW, 8'h28);
		wr(etm_pkg::OFS_COMPARE_B_LOW, 8'h28);
		for (int f = 0; f < 4; f++)
		begin
			set_mode(etm_pkg::MODE_COMPARE, 2'(f));
			pin(oc ^ pol);
			repeat (60) @(posedge clk);
			pin(cmp_level(2'(f), oc) ^ pol);
		end
		$display("test compare output done");
		d = 8'(16 + $urandom % 112);
		wr(etm_pkg::OFS_COMPARE_A_LOW, d);
		wr(etm_pkg::OFS_COMPARE_B_LOW, d);
		for (int f = 0; f < 4; f++)
		begin
			set_mode(etm_pkg::MODE_PWM, 2'(f));
			if (f < 2)
				pin((f == 1 ? oc : ~oc) ^ pol);
			else if (f == 2)
			begin
				n = 0;
				repeat (128)
				begin
					@(posedge clk);
					n += int'(a_out === (oc ^ pol));
				end
				chk("pwm active cycles", 32'(d), n);
			end
			else
			begin
				pin(oc ^ pol);
				repeat (int'(d) + 10) @(posedge clk);
				pin(~oc ^ pol);
				rd(etm_pkg::OFS_CONTROL0, 8'h11);
			end
		end
		$display("test pwm and pulse done");
		// Run rise leaves the count at 5 when set_mode returns
		set_mode(etm_pkg::MODE_CAPTURE, etm_pkg::FUNC_0);
		n = int'(3 + $urandom % 60);
		repeat (n) @(posedge clk);
		cap_in <= 1'b1;
		@(posedge clk);
		rd(etm_pkg::OFS_COMPARE_A_LOW, 8'(n + 5));
		rd(etm_pkg::OFS_COMPARE_B_LOW, 8'(n + 5));
		chk("output enables", 32'h0000_0000, 32'({a_oe, b_oe}));
		$display("test capture done");
		end_of_test();
	end
endmodule
